// *** design/cfc_pkg.sv ***
package cfc_pkg;
  localparam int PC_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int RPT_CONST_W = 8;
  localparam int RPT_MEM_W = 16;
  localparam int ACC_W = 32;
  localparam int COND_W = 10;

  // condition field layout
  localparam int COND_ACC_LSB = 0;
  localparam int COND_OVF_LSB = 3;
  localparam int COND_TC_LSB = 5;
  localparam int COND_CY_LSB = 7;
  localparam int COND_PIN_BIT = 9;

  // accumulator test codes
  localparam logic [2:0] ACC_NONE = 3'h0;
  localparam logic [2:0] ACC_ZERO = 3'h1;
  localparam logic [2:0] ACC_NONZERO = 3'h2;
  localparam logic [2:0] ACC_NEGATIVE = 3'h3;
  localparam logic [2:0] ACC_NONPOSITIVE = 3'h4;
  localparam logic [2:0] ACC_POSITIVE = 3'h5;
  localparam logic [2:0] ACC_NONNEGATIVE = 3'h6;
  localparam logic [2:0] ACC_BAD = 3'h7;

  // two-way flag test codes
  localparam logic [1:0] FLAG_NONE = 2'h0;
  localparam logic [1:0] FLAG_SET = 2'h1;
  localparam logic [1:0] FLAG_CLEAR = 2'h2;
  localparam logic [1:0] FLAG_BAD = 2'h3;

  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REPEAT = 8'h08;
  localparam logic [7:0] REG_STACK = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_TAKEN_BIT = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int STAT_RPT_BIT = 2;
  localparam logic CTRL_EN_RESET = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_BRANCH_IF = 3'b001,
    OP_LOOP_LOOP_BRANCH_AUX_NONZERO = 3'b010,
    OP_CALL_IF = 3'b011,
    OP_RETURN_IF = 3'b100,
    OP_REPEAT_NEXT = 3'b101
  } cfc_op_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_EXEC = 2'b10
  } cfc_state_e;
endpackage

// *** design/cfc_stack_if.sv ***
`timescale 1ns/100ps
interface cfc_stack_if;
  logic push;
  logic pop;
  logic [15:0] push_data;
  logic [15:0] top;
  modport ctl (output push, output pop, output push_data, input top);
  modport stk (input push, input pop, input push_data, output top);
endinterface

// *** design/cfc_stack.sv ***
`timescale 1ns/100ps
module cfc_stack
  import cfc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  cfc_stack_if.stk sif
);
  logic [PC_W-1:0] lvl [STACK_DEPTH];
  logic [PC_W-1:0] next_lvl [STACK_DEPTH];

  // push shifts down and drops the bottom; pop shifts up, bottom copies itself
  always_comb
  begin
    next_lvl = lvl;
    if (sif.push)
    begin
      next_lvl[0] = sif.push_data;
      for (int i = 1; i < STACK_DEPTH; i++)
        next_lvl[i] = lvl[i-1];
    end
    else if (sif.pop)
    begin
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        next_lvl[i] = lvl[i+1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
        lvl[i] <= 16'h0000;
    end
    else
      lvl <= next_lvl;
  end

  assign sif.top = lvl[0];
endmodule

// *** design/cfc_flow.sv ***
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module cfc_flow
  import cfc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic dec_valid,
  input wire logic [2:0] dec_op,
  input wire logic [COND_W-1:0] dec_cond,
  input wire logic [PC_W-1:0] dec_word2,
  input wire logic [PC_W-1:0] dec_next_pc,
  input wire logic [ACC_W-1:0] acc,
  input wire logic carry_flag,
  input wire logic ovf_flag,
  input wire logic tc_flag,
  input wire logic [15:0] aux_reg,
  input wire logic branch_pin_n,
  input wire logic rep_exec,
  output logic decode_stall,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic flush_two,
  output logic pm_operand_fetch
);
  cfc_stack_if sif();
  cfc_stack u_stack (.hclk(hclk), .hresetn(hresetn), .sif(sif));

  // pin synchroniser
  logic pin_s1;
  logic pin_s2;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end
    else
    begin
      pin_s1 <= branch_pin_n;
      pin_s2 <= pin_s1;
    end
  end

  // bus slave
  logic ap_write;
  logic [7:0] ap_addr;
  logic next_ap_write;
  logic [7:0] next_ap_addr;
  logic [31:0] next_hrdata;
  logic ctrl_en;
  logic next_ctrl_en;
  logic wr_ctrl;
  logic wr_status;
  logic wr_repeat;
  logic illegal;
  logic last_taken;
  logic rpt_act;
  logic [RPT_MEM_W-1:0] rpt_cnt;

  always_comb
  begin
    next_ap_write = 1'b0;
    next_ap_addr = ap_addr;
    next_hrdata = hrdata;
    if (hsel && htrans[1] && hready)
    begin
      next_ap_write = hwrite;
      next_ap_addr = haddr[7:0];
      case (haddr[7:0])
        REG_CTRL: next_hrdata = {31'h0, ctrl_en};
        REG_STATUS: next_hrdata = {29'h0, rpt_act, illegal, last_taken};
        REG_REPEAT: next_hrdata = {16'h0, rpt_cnt};
        REG_STACK: next_hrdata = {16'h0, sif.top};
        REG_PC: next_hrdata = {16'h0, pc_value};
        default: next_hrdata = 32'h0;
      endcase
    end
    wr_ctrl = ap_write && (ap_addr == REG_CTRL);
    wr_status = ap_write && (ap_addr == REG_STATUS);
    wr_repeat = ap_write && (ap_addr == REG_REPEAT);
    next_ctrl_en = wr_ctrl ? hwdata[CTRL_EN_BIT] : ctrl_en;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      ctrl_en <= CTRL_EN_RESET;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
      ctrl_en <= next_ctrl_en;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // flow control
  cfc_state_e state;
  cfc_state_e next_state;
  cfc_op_e cur_op;
  cfc_op_e next_cur_op;
  logic [COND_W-1:0] cur_cond;
  logic [COND_W-1:0] next_cur_cond;
  logic [PC_W-1:0] cur_word2;
  logic [PC_W-1:0] next_cur_word2;
  logic [PC_W-1:0] cur_next_pc;
  logic [PC_W-1:0] next_cur_next_pc;
  logic next_stall;
  logic next_pc_load;
  logic [PC_W-1:0] next_pc_value;
  logic next_flush;
  logic next_illegal;
  logic next_taken;
  logic cond_all;
  logic legal;
  logic taken;
  logic start_rpt;
  logic [2:0] c_acc;
  logic [1:0] c_ovf;
  logic [1:0] c_tc;
  logic [1:0] c_cy;
  logic acc_is_zero;
  logic acc_is_neg;

  always_comb
  begin
    c_acc = cur_cond[COND_ACC_LSB +: 3];
    c_ovf = cur_cond[COND_OVF_LSB +: 2];
    c_tc = cur_cond[COND_TC_LSB +: 2];
    c_cy = cur_cond[COND_CY_LSB +: 2];
    acc_is_zero = (acc == 32'h0000_0000);
    acc_is_neg = acc[ACC_W-1];
    // one code per category, so pairs within a category cannot be coded
    legal = (c_acc != ACC_BAD) && (c_ovf != FLAG_BAD)
      && (c_tc != FLAG_BAD) && (c_cy != FLAG_BAD);
    cond_all = 1'b1;
    case (c_acc)
      ACC_ZERO: cond_all = acc_is_zero;
      ACC_NONZERO: cond_all = !acc_is_zero;
      ACC_NEGATIVE: cond_all = acc_is_neg;
      ACC_NONPOSITIVE: cond_all = acc_is_neg || acc_is_zero;
      ACC_POSITIVE: cond_all = !acc_is_neg && !acc_is_zero;
      ACC_NONNEGATIVE: cond_all = !acc_is_neg;
      default: cond_all = 1'b1;
    endcase
    if (c_ovf == FLAG_SET) cond_all = cond_all && ovf_flag;
    if (c_ovf == FLAG_CLEAR) cond_all = cond_all && !ovf_flag;
    if (c_tc == FLAG_SET) cond_all = cond_all && tc_flag;
    if (c_tc == FLAG_CLEAR) cond_all = cond_all && !tc_flag;
    if (c_cy == FLAG_SET) cond_all = cond_all && carry_flag;
    if (c_cy == FLAG_CLEAR) cond_all = cond_all && !carry_flag;
    if (cur_cond[COND_PIN_BIT]) cond_all = cond_all && !pin_s2;
    if (cur_op == OP_LOOP_LOOP_BRANCH_AUX_NONZERO)
      taken = (aux_reg != 16'h0000);
    else
      taken = legal && cond_all;
  end

  always_comb
  begin
    next_state = state;
    next_cur_op = cur_op;
    next_cur_cond = cur_cond;
    next_cur_word2 = cur_word2;
    next_cur_next_pc = cur_next_pc;
    next_stall = decode_stall;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_flush = 1'b0;
    next_taken = last_taken;
    next_illegal = illegal;
    start_rpt = 1'b0;
    sif.push = 1'b0;
    sif.pop = 1'b0;
    sif.push_data = cur_next_pc;
    if (wr_status && hwdata[STAT_ILLEGAL_BIT])
      next_illegal = 1'b0;
    case (state)
      S_IDLE:
      begin
        if (dec_valid && ctrl_en)
        begin
          if (dec_op == OP_REPEAT_NEXT)
            start_rpt = 1'b1;
          else if (dec_op != OP_NONE && dec_op <= OP_RETURN_IF)
          begin
            next_state = S_WAIT;
            next_stall = 1'b1;
            next_cur_op = cfc_op_e'(dec_op);
            next_cur_cond = dec_cond;
            next_cur_word2 = dec_word2;
            next_cur_next_pc = dec_next_pc;
          end
        end
      end
      S_WAIT: next_state = S_EXEC;
      S_EXEC:
      begin
        next_state = S_IDLE;
        next_stall = 1'b0;
        next_taken = taken;
        if (!legal && cur_op != OP_LOOP_LOOP_BRANCH_AUX_NONZERO)
          next_illegal = 1'b1;
        if (taken)
        begin
          next_pc_load = 1'b1;
          next_flush = 1'b1;
          next_pc_value = cur_word2;
          if (cur_op == OP_CALL_IF)
            sif.push = 1'b1;
          if (cur_op == OP_RETURN_IF)
          begin
            sif.pop = 1'b1;
            next_pc_value = sif.top;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= S_IDLE;
      cur_op <= OP_NONE;
      cur_cond <= 10'h000;
      cur_word2 <= 16'h0000;
      cur_next_pc <= 16'h0000;
      decode_stall <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= 16'h0000;
      flush_two <= 1'b0;
      last_taken <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur_op <= next_cur_op;
      cur_cond <= next_cur_cond;
      cur_word2 <= next_cur_word2;
      cur_next_pc <= next_cur_next_pc;
      decode_stall <= next_stall;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      flush_two <= next_flush;
      last_taken <= next_taken;
      illegal <= next_illegal;
    end
  end

  // repeat counter
  logic next_rpt_act;
  logic [RPT_MEM_W-1:0] next_rpt_cnt;

  always_comb
  begin
    next_rpt_act = rpt_act;
    next_rpt_cnt = rpt_cnt;
    if (start_rpt)
    begin
      next_rpt_cnt = {8'h00, dec_word2[RPT_CONST_W-1:0]};
      next_rpt_act = 1'b1;
    end
    else if (wr_repeat)
    begin
      next_rpt_cnt = hwdata[RPT_MEM_W-1:0];
      next_rpt_act = 1'b1;
    end
    else if (rpt_act && rep_exec)
    begin
      if (rpt_cnt == 16'h0000)
        next_rpt_act = 1'b0;
      else
        next_rpt_cnt = rpt_cnt - 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rpt_act <= 1'b0;
      rpt_cnt <= 16'h0000;
      pm_operand_fetch <= 1'b0;
    end
    else
    begin
      rpt_act <= next_rpt_act;
      rpt_cnt <= next_rpt_cnt;
      pm_operand_fetch <= next_rpt_act;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_carry;
    state == S_EXEC && cur_op == OP_BRANCH_IF && c_cy == FLAG_CLEAR && carry_flag |=> !pc_load;
  endproperty
  a_carry: assert property (p_carry) else $error("carry clear taken with carry set");
  property p_ovf;
    state == S_EXEC && cur_op == OP_BRANCH_IF && c_ovf == FLAG_SET && !ovf_flag |=> !last_taken;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow test taken without overflow");
  property p_tc;
    state == S_EXEC && cur_op == OP_CALL_IF && c_tc == FLAG_SET && !tc_flag |=> !flush_two;
  endproperty
  a_tc: assert property (p_tc) else $error("test flag call taken while flag clear");
  property p_stall;
    state == S_IDLE && dec_valid && ctrl_en && dec_op inside {OP_BRANCH_IF, OP_CALL_IF}
      |=> decode_stall [*2] ##1 !decode_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("stall is not two cycles");
  property p_branch;
    state == S_EXEC && cur_op == OP_BRANCH_IF && taken
      |=> pc_load && flush_two && pc_value == $past(cur_word2);
  endproperty
  a_branch: assert property (p_branch) else $error("taken branch target or flush wrong");
  property p_notaken;
    state == S_EXEC && !taken |=> !pc_load && !flush_two;
  endproperty
  a_notaken: assert property (p_notaken) else $error("false condition transferred");
  property p_loop_branch_aux_nonzero;
    state == S_EXEC && cur_op == OP_LOOP_LOOP_BRANCH_AUX_NONZERO && aux_reg == 16'h0000 |=> !pc_load;
  endproperty
  a_loop_branch_aux_nonzero: assert property (p_loop_branch_aux_nonzero) else $error("loop branch taken on zero");
  property p_call;
    state == S_EXEC && cur_op == OP_CALL_IF && taken |=> sif.top == $past(cur_next_pc);
  endproperty
  a_call: assert property (p_call) else $error("call did not push return address");
  property p_ret;
    state == S_EXEC && cur_op == OP_RETURN_IF && taken |=> pc_value == $past(sif.top);
  endproperty
  a_ret: assert property (p_ret) else $error("return did not load stack top");
  property p_rpt;
    rpt_act && rep_exec && rpt_cnt != 16'h0000 && !start_rpt && !wr_repeat
      |=> rpt_act && rpt_cnt == $past(rpt_cnt) - 16'h0001;
  endproperty
  a_rpt: assert property (p_rpt) else $error("repeat count did not step");
  c_branch_taken: cover property (state == S_EXEC && cur_op == OP_BRANCH_IF && taken);
  c_call_taken: cover property (state == S_EXEC && cur_op == OP_CALL_IF && taken);
  c_return_taken: cover property (state == S_EXEC && cur_op == OP_RETURN_IF && taken);
  c_repeat_end: cover property (rpt_act ##1 !rpt_act);
endmodule

// *** verif/cfc_pm_model.sv ***
`timescale 1ns/100ps
module cfc_pm_model
  import cfc_pkg::*;
(
  input wire logic hclk,
  input wire logic decode_stall,
  input wire logic pm_operand_fetch,
  output logic dec_valid,
  output logic [2:0] dec_op,
  output logic [COND_W-1:0] dec_cond,
  output logic [PC_W-1:0] dec_word2,
  output logic [PC_W-1:0] dec_next_pc,
  output logic rep_exec
);
  initial
  begin
    dec_valid = 1'b0;
    dec_op = OP_NONE;
    dec_cond = '0;
    dec_word2 = '0;
    dec_next_pc = '0;
    rep_exec = 1'b0;
  end

  // one instruction word pair, then counts the stall cycles that follow
  task automatic offer(input logic [2:0] op, input logic [COND_W-1:0] c,
    input logic [PC_W-1:0] w2, input logic [PC_W-1:0] np, output int st);
    st = 0;
    @(posedge hclk);
    while (decode_stall === 1'b1) @(posedge hclk);
    dec_valid <= 1'b1;
    dec_op <= op;
    dec_cond <= c;
    dec_word2 <= w2;
    dec_next_pc <= np;
    @(posedge hclk);
    dec_valid <= 1'b0;
    dec_op <= OP_NONE;
    // released words no longer show the last value
    dec_word2 <= ~w2;
    dec_next_pc <= ~np;
    repeat (3)
    begin
      @(posedge hclk);
      if (decode_stall === 1'b1) st++;
    end
  endtask

  // executes the repeated instruction, sometimes with gaps
  task automatic run_reps(output int n);
    n = 0;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge hclk);
      if (rep_exec === 1'b1 && pm_operand_fetch === 1'b1) n++;
      if (pm_operand_fetch !== 1'b1) break;
      rep_exec <= 1'(($urandom % 3) != 0);
    end
    rep_exec <= 1'b0;
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb
  import cfc_pkg::*;
();
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic dec_valid, carry_flag, ovf_flag, tc_flag, branch_pin_n, rep_exec;
  logic [2:0] dec_op;
  logic [COND_W-1:0] dec_cond, c;
  logic [PC_W-1:0] dec_word2, dec_next_pc, pc_value, w;
  logic [ACC_W-1:0] acc;
  logic [15:0] aux_reg;
  logic decode_stall, pc_load, flush_two, pm_operand_fetch;
  logic [2:0] ops[3] = '{OP_BRANCH_IF, OP_CALL_IF, OP_LOOP_LOOP_BRANCH_AUX_NONZERO};
  logic [COND_W-1:0] bad[4] = '{10'h007, 10'h018, 10'h060, 10'h180};
  logic [15:0] rw[2] = '{16'hAB03, 16'h00FF};
  int rn[3] = '{4, 256, 257};
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [15:0] exp_pc[$];
  assign hready = hreadyout;

  cfc_flow u_cfc_flow (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .dec_valid, .dec_op, .dec_cond,
    .dec_word2, .dec_next_pc, .acc, .carry_flag, .ovf_flag, .tc_flag, .aux_reg,
    .branch_pin_n, .rep_exec, .decode_stall, .pc_load, .pc_value, .flush_two,
    .pm_operand_fetch);
  cfc_pm_model u_cfc_pm_model (.hclk, .decode_stall, .pm_operand_fetch, .dec_valid,
    .dec_op, .dec_cond, .dec_word2, .dec_next_pc, .rep_exec);

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  // every pc load must match the oldest expected target
  always @(posedge hclk)
    if (hresetn === 1'b1 && pc_load === 1'b1)
    begin
      if (exp_pc.size() == 0)
        check_val(pc_value, 32'h10000);
      else
        check_val(pc_value, exp_pc.pop_front());
      check_val(flush_two, 32'h1);
    end

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check_val(hresp, 32'h0);
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, $urandom, d);
    check_val(d & m, e);
  endtask

  function automatic logic fok(input logic [1:0] k, input logic f);
    return k == FLAG_NONE || (k == FLAG_SET && f) || (k == FLAG_CLEAR && !f);
  endfunction

  function automatic logic taken(input logic [COND_W-1:0] k);
    logic signed [31:0] a;
    logic t;
    a = acc;
    case (k[2:0])
      ACC_ZERO: t = a == 0;
      ACC_NONZERO: t = a != 0;
      ACC_NEGATIVE: t = a < 0;
      ACC_NONPOSITIVE: t = a <= 0;
      ACC_POSITIVE: t = a > 0;
      ACC_NONNEGATIVE: t = a >= 0;
      ACC_BAD: t = 1'b0;
      default: t = 1'b1;
    endcase
    t = t && fok(k[4:3], ovf_flag) && fok(k[6:5], tc_flag);
    return t && fok(k[8:7], carry_flag) && !(k[9] && branch_pin_n);
  endfunction

  task automatic go(input logic [2:0] op, input logic [COND_W-1:0] k,
    input logic [15:0] w2, input logic [15:0] np, input logic [15:0] ep, input int est);
    int st;
    logic tk;
    // lets the pin synchroniser settle
    repeat (3) @(posedge hclk);
    tk = (op == OP_LOOP_LOOP_BRANCH_AUX_NONZERO) ? (aux_reg != 16'h0) : taken(k);
    if (tk && est == 2) exp_pc.push_back(ep);
    u_cfc_pm_model.offer(op, k, w2, np, st);
    check_val(st, est);
    if (est == 2 && op != OP_LOOP_LOOP_BRANCH_AUX_NONZERO) rd_chk(REG_STATUS, 32'h1, tk);
  endtask

  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    {acc, carry_flag, ovf_flag, tc_flag, aux_reg} = '0;
    branch_pin_n = 1'b1;
    n = $urandom(32'hE4E1);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    check_val(pc_value, 32'h0);
    rd_chk(REG_CTRL, 32'h1, 32'h1);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge hclk);
      case ($urandom % 4)
        0: acc <= 32'h0;
        1: acc <= 32'h8000_0000;
        2: acc <= 32'h1;
        default: acc <= $urandom;
      endcase
      {carry_flag, ovf_flag, tc_flag, branch_pin_n} <= 4'($urandom);
      aux_reg <= ($urandom % 2) ? 16'h0 : 16'($urandom);
      c = {1'($urandom), 2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3),
        3'($urandom % 7)};
      w = 16'($urandom);
      go(ops[$urandom % 3], c, w, w + 16'h1, w, 2);
    end
    foreach (bad[i])
    begin
      go(OP_BRANCH_IF, bad[i], 16'h5555, 16'h0, 16'h5555, 2);
      rd_chk(REG_STATUS, 32'h2, 32'h2);
      wr(REG_STATUS, 32'h2);
      rd_chk(REG_STATUS, 32'h2, 32'h0);
    end
    wr(REG_CTRL, 32'h0);
    go(OP_BRANCH_IF, 10'h0, 16'h3333, 16'h0, 16'h3333, 0);
    wr(REG_CTRL, 32'h1);
    // unused op code is refused: no stall, no pc load
    go(3'h7, 10'h0, 16'h3333, 16'h0, 16'h3333, 0);
    // second reset empties the stack
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 1; i <= 9; i++)
      go(OP_CALL_IF, 10'h0, 16'(16'h4000 + i), 16'(16'h1000 + i), 16'(16'h4000 + i), 2);
    tc_flag <= 1'b0;
    go(OP_RETURN_IF, 10'h020, 16'h0, 16'h0, 16'h0, 2);
    rd_chk(REG_STACK, 32'hFFFF, 32'h1009);
    for (int i = 1; i <= 9; i++)
      go(OP_RETURN_IF, 10'h0, 16'h0, 16'h0, (i < 9) ? 16'(16'h100A - i) : 16'h1002, 2);
    rd_chk(REG_PC, 32'hFFFF, 32'h1002);
    for (int i = 0; i < 3; i++)
    begin
      if (i < 2)
        u_cfc_pm_model.offer(OP_REPEAT_NEXT, 10'h0, rw[i], 16'h0, n);
      else
        wr(REG_REPEAT, 32'h0100);
      @(negedge hclk);
      check_val(pm_operand_fetch, 32'h1);
      rd_chk(REG_STATUS, 32'h4, 32'h4);
      if (i == 2) rd_chk(REG_REPEAT, 32'hFFFF, 32'h100);
      u_cfc_pm_model.run_reps(n);
      check_val(n, rn[i]);
      rd_chk(REG_STATUS, 32'h4, 32'h0);
    end
    repeat (5) @(posedge hclk);
    check_val(exp_pc.size(), 32'h0);
    tally_and_finish();
  end
endmodule
